// ===== src/clock_gate_pkg.sv
// Package for the sleep clock-gating block: register map and field layout.
// Assumes a 32-bit AXI4-Lite register bus on a single system clock.
package clock_gate_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int UNIT_N = 12;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] RUN_CLOCK_GATE_1_OFS = 12'h104;
    localparam logic [ADDR_W-1:0] SLEEP_CLOCK_GATE_1_OFS = 12'h114;
    localparam logic [ADDR_W-1:0] DEEP_SLEEP_CLOCK_GATE_1_OFS = 12'h124;
    localparam logic [ADDR_W-1:0] RUN_CLOCK_CONFIG_OFS = 12'h060;
    localparam logic [ADDR_W-1:0] FAULT_STATUS_OFS = 12'h200;
    localparam logic [ADDR_W-1:0] FAULT_MASK_OFS = 12'h204;

    // Writable enable bits of each gating register
    localparam logic [DATA_W-1:0] GATE_RW_MASK = 32'h030F5033;
    localparam logic [DATA_W-1:0] GATE_RESET = 32'h00000000;

    // Bit position of each unit in the gating registers, unit index 0..11
    localparam int UNIT_BIT [UNIT_N] = '{0, 1, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25};

    localparam int AUTO_GATING_SELECT_BIT = 27;
    localparam logic [DATA_W-1:0] RUN_CLOCK_CONFIG_MASK = 32'h08000000;
    localparam logic [DATA_W-1:0] RUN_CLOCK_CONFIG_RESET = 32'h00000000;

    // Fault status bits: bit 0 fault on a gated unit, bit 1 unmapped address
    localparam int FAULT_GATED_BIT = 0;
    localparam int FAULT_UNMAPPED_BIT = 1;
    localparam logic [DATA_W-1:0] FAULT_MASK_BITS = 32'h00000003;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_DEEP_SLEEP
    } power_state_t;

endpackage

// ===== src/unit_access_if.sv
// Interface carrying a peripheral unit access check between the top and the selector.
// Assumes one system clock domain.
`timescale 1ns/1ps
interface unit_access_if;
    import clock_gate_pkg::*;
    logic [UNIT_N-1:0] enable; // Effective per-unit clock enables
    logic [UNIT_N-1:0] access; // One-hot unit access request
    logic fault; // Access hits a gated unit
    modport selector (output enable, output fault, input access);
    modport top (input enable, input fault, output access);
endinterface

// ===== src/gate_select.sv
// Chooses the gating word that applies in the present power state and maps it
// to per-unit enables; flags accesses to units whose clock is off.
// Assumes power state and gating words are on the system clock.
`timescale 1ns/1ps
module gate_select
    import clock_gate_pkg::*;
(
    input wire logic [DATA_W-1:0] run_gate, // Run gating word
    input wire logic [DATA_W-1:0] sleep_gate, // Sleep gating word
    input wire logic [DATA_W-1:0] deep_gate, // Deep-sleep gating word
    input wire logic auto_gating_select, // Sleep registers take effect
    input wire power_state_t power_state, // Present power state
    unit_access_if.selector ua // Enable and fault check
);
    logic [DATA_W-1:0] word;

    always_comb begin
        unique case (power_state)
            PWR_RUN: word = run_gate;
            PWR_SLEEP: word = auto_gating_select ? sleep_gate : run_gate;
            PWR_DEEP_SLEEP: word = auto_gating_select ? deep_gate : run_gate;
            default: word = run_gate;
        endcase
    end

    genvar i;
    generate
        for (i = 0; i < UNIT_N; i++) begin : g_unit
            assign ua.enable[i] = word[UNIT_BIT[i]];
        end
    endgenerate

    assign ua.fault = |(ua.access & ~ua.enable);
endmodule // gate_select

// ===== src/sleep_clock_gating.sv
// Sleep clock-gating register block with its run and deep-sleep companions,
// an AXI4-Lite slave and a fault interrupt.
// Assumes aclk is the system clock and power state and unit accesses are synchronous to it.
//
// Contract
// - Each implemented gating bit is the clock enable of one unit, on when set.
// - An access to a unit whose clock is gated off raises a bus fault.
// - The sleep gating register resets to all zeros, leaving all units off.
// - Three gating registers exist, for run, sleep and deep-sleep states.
// - The sleep-state registers apply only while the auto-gating select is set.
// - Bits 25 and 24 enable analog comparators 1 and 0.
// - Bits 19 to 16 enable timers 3 to 0.
// - Bits 14 and 12 enable two-wire modules 1 and 0.
// - Bits 5 and 4 enable synchronous serial modules 1 and 0.
// - Bits 1 and 0 enable asynchronous serial ports 1 and 0.
// - Reserved bits read zero and ignore writes.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
module sleep_clock_gating
    import clock_gate_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic [2:0] s_axi_awprot, // Write protection, unused
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [DATA_W-1:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic [2:0] s_axi_arprot, // Read protection, unused
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [DATA_W-1:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire power_state_t power_state, // Present power state
    input wire logic [UNIT_N-1:0] unit_access, // One-hot unit access strobe
    output logic [UNIT_N-1:0] unit_clock_enable, // Per-unit clock enable
    output logic unit_bus_fault, // Pulse: access hit a gated unit
    output logic irq // Level interrupt
);
    logic [DATA_W-1:0] run_clock_gate_1;
    logic [DATA_W-1:0] sleep_clock_gate_1;
    logic [DATA_W-1:0] deep_sleep_clock_gate_1;
    logic [DATA_W-1:0] run_clock_config;
    logic [DATA_W-1:0] fault_status;
    logic [DATA_W-1:0] fault_mask;

    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_mapped;
    logic rd_mapped;
    logic [DATA_W-1:0] rd_word;
    logic unmapped_event;
    logic gated_event;

    unit_access_if ua ();

    assign ua.access = unit_access;

    gate_select u_gate_select (
        .run_gate(run_clock_gate_1),
        .sleep_gate(sleep_clock_gate_1),
        .deep_gate(deep_sleep_clock_gate_1),
        .auto_gating_select(run_clock_config[AUTO_GATING_SELECT_BIT]),
        .power_state(power_state),
        .ua(ua)
    );

    // Byte-lane merge restricted to writable bits
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] new_val,
        input logic [3:0] strb,
        input logic [DATA_W-1:0] rw_mask
    );
        logic [DATA_W-1:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old_val & ~(lanes & rw_mask)) | (new_val & lanes & rw_mask);
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        is_mapped = (addr == RUN_CLOCK_GATE_1_OFS) || (addr == SLEEP_CLOCK_GATE_1_OFS)
            || (addr == DEEP_SLEEP_CLOCK_GATE_1_OFS) || (addr == RUN_CLOCK_CONFIG_OFS)
            || (addr == FAULT_STATUS_OFS) || (addr == FAULT_MASK_OFS);
    endfunction

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_mapped = is_mapped(aw_addr);
    assign rd_mapped = is_mapped(s_axi_araddr);

    always_comb begin
        unique case (s_axi_araddr)
            RUN_CLOCK_GATE_1_OFS: rd_word = run_clock_gate_1 & GATE_RW_MASK;
            SLEEP_CLOCK_GATE_1_OFS: rd_word = sleep_clock_gate_1 & GATE_RW_MASK;
            DEEP_SLEEP_CLOCK_GATE_1_OFS: rd_word = deep_sleep_clock_gate_1 & GATE_RW_MASK;
            RUN_CLOCK_CONFIG_OFS: rd_word = run_clock_config;
            FAULT_STATUS_OFS: rd_word = fault_status;
            FAULT_MASK_OFS: rd_word = fault_mask;
            default: rd_word = '0;
        endcase
    end

    // Write address channel: hold one address until the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awready && s_axi_awvalid) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awready && s_axi_awvalid) && !s_axi_bvalid;
        end
    end

    // Write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wready && s_axi_wvalid) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !(s_axi_wready && s_axi_wvalid) && !s_axi_bvalid;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Gating registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_clock_gate_1 <= GATE_RESET;
            sleep_clock_gate_1 <= GATE_RESET;
            deep_sleep_clock_gate_1 <= GATE_RESET;
        end else if (do_write) begin
            if (aw_addr == RUN_CLOCK_GATE_1_OFS) begin
                run_clock_gate_1 <= merge(run_clock_gate_1, w_data, w_strb, GATE_RW_MASK);
            end
            if (aw_addr == SLEEP_CLOCK_GATE_1_OFS) begin
                // Only bits 25:24, 19:16, 14, 12, 5:4, 1:0 take writes
                sleep_clock_gate_1 <= merge(sleep_clock_gate_1, w_data, w_strb,
                    GATE_RW_MASK);
            end
            if (aw_addr == DEEP_SLEEP_CLOCK_GATE_1_OFS) begin
                deep_sleep_clock_gate_1 <= merge(deep_sleep_clock_gate_1, w_data, w_strb,
                    GATE_RW_MASK);
            end
        end
    end

    // Run clock configuration holding the auto-gating select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_clock_config <= RUN_CLOCK_CONFIG_RESET;
        end else if (do_write && aw_addr == RUN_CLOCK_CONFIG_OFS) begin
            run_clock_config <= merge(run_clock_config, w_data, w_strb,
                RUN_CLOCK_CONFIG_MASK);
        end
    end

    // Read channel: one read at a time, answered the edge after acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arready && s_axi_arvalid);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arready && s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign unmapped_event = (do_write && !wr_mapped)
        || (s_axi_arready && s_axi_arvalid && !rd_mapped);
    assign gated_event = ua.fault;

    // Fault pulse to the bus fabric
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_bus_fault <= 1'b0;
        end else begin
            unit_bus_fault <= gated_event;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_clock_enable <= '0;
        end else begin
            unit_clock_enable <= ua.enable;
        end
    end

    // Sticky fault status, write one to clear; a new event wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_status <= '0;
        end else begin
            if (do_write && aw_addr == FAULT_STATUS_OFS && w_strb[0]) begin
                fault_status <= fault_status & ~(w_data & FAULT_MASK_BITS);
            end
            if (gated_event) begin
                fault_status[FAULT_GATED_BIT] <= 1'b1;
            end
            if (unmapped_event) begin
                fault_status[FAULT_UNMAPPED_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_mask <= '0;
        end else if (do_write && aw_addr == FAULT_MASK_OFS) begin
            fault_mask <= merge(fault_mask, w_data, w_strb, FAULT_MASK_BITS);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(fault_status & fault_mask);
        end
    end

endmodule // sleep_clock_gating

// ===== tb/sleep_clock_gating_sva.sv
// Port-level assertions for the sleep clock-gating block, bound to its top.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/1ps
module sleep_clock_gating_sva
    import clock_gate_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    input wire logic s_axi_wvalid, // W valid
    input wire logic s_axi_wready, // W ready
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arvalid, // AR valid
    input wire logic s_axi_arready, // AR ready
    input wire logic s_axi_rvalid, // R valid
    input wire power_state_t power_state, // Power state
    input wire logic [UNIT_N-1:0] unit_access, // Access strobes
    input wire logic [UNIT_N-1:0] unit_clock_enable, // Enables
    input wire logic unit_bus_fault // Fault pulse
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_write_answer;
        !s_axi_awready && !s_axi_wready ##[0:1] s_axi_bvalid;
    endsequence
    property p_reset_idle;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && unit_clock_enable == '0;
    endproperty
    property p_fault_match;
        $stable(unit_clock_enable) && $past(aresetn)
            |-> unit_bus_fault == $past(|(unit_access & ~unit_clock_enable));
    endproperty
    property p_enable_cause;
        !$stable(unit_clock_enable)
            |-> $past(s_axi_bvalid) || $past(power_state) != $past(power_state, 2);
    endproperty
    property p_write_answer;
        s_write_taken |=> s_write_answer;
    endproperty
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
    endproperty
    property p_write_refused;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_read_refused;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_b_taken;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
    a_fault_match: assert property (p_fault_match) else $error("fault mismatch");
    a_enable_cause: assert property (p_enable_cause) else $error("enable moved");
    a_write_answer: assert property (p_write_answer) else $error("write answer late");
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    a_write_refused: assert property (p_write_refused) else $error("write ready high");
    a_read_refused: assert property (p_read_refused) else $error("read ready high");
    a_b_taken: assert property (p_b_taken) else $error("write response stuck");
endmodule // sleep_clock_gating_sva
bind sleep_clock_gating sleep_clock_gating_sva chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .power_state(power_state),
    .unit_access(unit_access), .unit_clock_enable(unit_clock_enable),
    .unit_bus_fault(unit_bus_fault)
);

// ===== tb/test_sleep_clock_gating.sv
// Self-checking bench for the sleep clock-gating block over its register bus.
// Assumes the package gives the register map and the unit bit order.
`timescale 1ns/1ps
module test_sleep_clock_gating import clock_gate_pkg::*;;
    typedef struct {
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        logic [3:0] s;
        logic [DATA_W-1:0] e;
    } row_t;
    localparam logic [DATA_W-1:0] RUN_W = 32'h01064022;
    localparam logic [DATA_W-1:0] SLEEP_W = 32'h00000033;
    localparam logic [DATA_W-1:0] DEEP_W = 32'h030F5033;
    localparam logic [ADDR_W-1:0] RST_ADDRS [5] = '{RUN_CLOCK_GATE_1_OFS,
        SLEEP_CLOCK_GATE_1_OFS, DEEP_SLEEP_CLOCK_GATE_1_OFS, RUN_CLOCK_CONFIG_OFS, FAULT_MASK_OFS};
    row_t rows [6] = '{
        '{SLEEP_CLOCK_GATE_1_OFS, 32'hFFFFFFFF, 4'hF, 32'h030F5033},
        '{SLEEP_CLOCK_GATE_1_OFS, 32'h02085011, 4'hF, 32'h02085011},
        '{SLEEP_CLOCK_GATE_1_OFS, 32'hFCF0AFCC, 4'hF, 32'h00000000},
        '{SLEEP_CLOCK_GATE_1_OFS, 32'hFFFFFFFF, 4'h1, SLEEP_W},
        '{RUN_CLOCK_GATE_1_OFS, RUN_W, 4'hF, RUN_W},
        '{DEEP_SLEEP_CLOCK_GATE_1_OFS, 32'hFFFFFFFF, 4'hF, DEEP_W}};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [DATA_W-1:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    power_state_t power_state = PWR_RUN;
    logic [UNIT_N-1:0] unit_access = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, got_resp;
    logic [DATA_W-1:0] s_axi_rdata, got_data;
    logic [UNIT_N-1:0] unit_clock_enable, sleep_en;
    logic unit_bus_fault, irq;
    int fail_count = 0;
    int checked = 0;
    always #2.5 aclk = ~aclk;
    sleep_clock_gating uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .power_state(power_state),
        .unit_access(unit_access), .unit_clock_enable(unit_clock_enable),
        .unit_bus_fault(unit_bus_fault), .irq(irq)
    );
    function automatic logic [UNIT_N-1:0] exp_en(input logic [DATA_W-1:0] w);
        for (int i = 0; i < UNIT_N; i++) exp_en[i] = w[UNIT_BIT[i]];
    endfunction
    task automatic cmp_word(input string what, input logic [DATA_W-1:0] exp, got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_resp(input string what, input logic [1:0] exp, got);
        cmp_word(what, DATA_W'(exp), DATA_W'(got));
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] s);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        cmp_word("write handshake", 32'h00000001, DATA_W'(s_axi_bvalid));
        s_axi_bready <= 1'b0;
        got_resp = s_axi_bresp;
        // One idle edge so the next call never re-raises bready in this step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        cmp_word("read handshake", 32'h00000001, DATA_W'(s_axi_rvalid));
        s_axi_rready <= 1'b0;
        got_data = s_axi_rdata;
        got_resp = s_axi_rresp;
        // One idle edge so the next call never re-raises rready in this step
        @(posedge aclk);
    endtask
    task automatic set_state(input power_state_t ps);
        power_state <= ps;
        repeat (2) @(posedge aclk);
    endtask
    task automatic hit(input int u);
        unit_access <= UNIT_N'(1) << u;
        @(posedge aclk);
        unit_access <= '0;
        @(posedge aclk);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        sleep_en = exp_en(SLEEP_W);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        foreach (RST_ADDRS[i]) begin
            rd(RST_ADDRS[i]);
            cmp_word("reset value", GATE_RESET, got_data);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d, rows[i].s);
            cmp_resp("write resp", RESP_OKAY, got_resp);
            rd(rows[i].a);
            cmp_resp("read resp", RESP_OKAY, got_resp);
            cmp_word("readback", rows[i].e, got_data);
        end
        wr(12'h300, 32'hFFFFFFFF, 4'hF);
        cmp_resp("unmapped write", RESP_DECERR, got_resp);
        rd(12'h300);
        cmp_resp("unmapped read", RESP_DECERR, got_resp);
        cmp_word("run enables", DATA_W'(exp_en(RUN_W)), DATA_W'(unit_clock_enable));
        set_state(PWR_SLEEP);
        cmp_word("sleep, select clear", DATA_W'(exp_en(RUN_W)), DATA_W'(unit_clock_enable));
        wr(RUN_CLOCK_CONFIG_OFS, 32'hFFFFFFFF, 4'hF);
        rd(RUN_CLOCK_CONFIG_OFS);
        cmp_word("config", RUN_CLOCK_CONFIG_MASK, got_data);
        set_state(PWR_SLEEP);
        cmp_word("sleep enables", DATA_W'(sleep_en), DATA_W'(unit_clock_enable));
        for (int u = 0; u < UNIT_N; u++) begin
            hit(u);
            cmp_word("unit fault", DATA_W'(!sleep_en[u]), DATA_W'(unit_bus_fault));
        end
        set_state(PWR_DEEP_SLEEP);
        cmp_word("deep enables", DATA_W'(exp_en(DEEP_W)), DATA_W'(unit_clock_enable));
        hit(4);
        cmp_word("enabled unit fault", '0, DATA_W'(unit_bus_fault));
        cmp_word("irq masked", '0, DATA_W'(irq));
        rd(FAULT_STATUS_OFS);
        cmp_word("fault status", 32'h00000003, got_data);
        wr(FAULT_MASK_OFS, 32'h00000001, 4'hF);
        rd(FAULT_MASK_OFS);
        cmp_word("mask readback", 32'h00000001, got_data);
        cmp_word("irq unmasked", 32'h00000001, DATA_W'(irq));
        wr(FAULT_STATUS_OFS, 32'h00000003, 4'hF);
        rd(FAULT_STATUS_OFS);
        cmp_word("status cleared", '0, got_data);
        cmp_word("irq cleared", '0, DATA_W'(irq));
        rd(SLEEP_CLOCK_GATE_1_OFS);
        wr(SLEEP_CLOCK_GATE_1_OFS, got_data | 32'h02000000, 4'hF);
        rd(SLEEP_CLOCK_GATE_1_OFS);
        cmp_word("read-modify-write", SLEEP_W | 32'h02000000, got_data);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(SLEEP_CLOCK_GATE_1_OFS);
        cmp_word("second reset", GATE_RESET, got_data);
        cmp_word("second reset enables", '0, DATA_W'(unit_clock_enable));
        tally_and_finish();
    end
endmodule // test_sleep_clock_gating
